/* File: common/pdl_pkg.sv */
package pdl_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int PHASE_WIN_NS = 100;
  localparam int PHASE_WIN_CYC = (PHASE_WIN_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 PHASE_WIN_NS / CLK_PERIOD_NS;
  localparam int REF_TIMEOUT_NS = 10000;
  localparam int REF_TIMEOUT_CYC = (REF_TIMEOUT_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   REF_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int LRST_MIN_NS = 20;
  localparam int LRST_MIN_CYC = (LRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                                (LRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Widths
  localparam int RATIO_W = 7;
  localparam int QUAL_W = 9;
  localparam int CNT_W = 10;
  localparam int NUM_VDIV = 5;
  localparam logic [RATIO_W-1:0] RATIO_ONE = 7'h01;
  // Ratio, qualification count and feedback select limits
  localparam logic [QUAL_W-1:0] PRE_MIN = 9'h001;
  localparam logic [QUAL_W-1:0] PRE_MAX = 9'h028;
  localparam logic [QUAL_W-1:0] VDIV_MIN = 9'h002;
  localparam logic [QUAL_W-1:0] VDIV_MAX = 9'h050;
  localparam logic [QUAL_W-1:0] QUAL_MIN = 9'h010;
  localparam logic [QUAL_W-1:0] QUAL_MAX = 9'h100;
  localparam logic [2:0] FBSEL_MAX = 3'h4;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_M_RATIO = 8'h04;
  localparam logic [7:0] ADDR_N_RATIO = 8'h08;
  localparam logic [7:0] ADDR_QUAL = 8'h0C;
  localparam logic [7:0] ADDR_V_BASE = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h2C;
  // Control, status and interrupt bit fields
  localparam int CTRL_FREQ_BIT = 0;
  localparam int CTRL_MBYP_BIT = 1;
  localparam int CTRL_NBYP_BIT = 2;
  localparam int CTRL_PBYP_BIT = 3;
  localparam int CTRL_FBSEL_LSB = 4;
  localparam int STAT_QCNT_LSB = 16;
  localparam int IRQ_GAIN_BIT = 0;
  localparam int IRQ_LOSS_BIT = 1;
  // Reset values
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [RATIO_W-1:0] PRE_RESET = 7'h01;
  localparam logic [RATIO_W-1:0] VDIV_RESET = 7'h02;
  localparam logic [QUAL_W-1:0] QUAL_RESET = 9'h010;
  localparam logic [1:0] IRQ_RESET = 2'h0;
endpackage

/* File: common/pdl_div_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pdl_div_if;
  logic clear;
  logic event_in;
  logic [pdl_pkg::RATIO_W-1:0] ratio;
  logic level;
  logic tick;
  logic rise;
  modport drv (output clear, output event_in, output ratio, input level, input tick, input rise);
  modport div (input clear, input event_in, input ratio, output level, output tick, output rise);
endinterface
`default_nettype wire

/* File: rtl/pdl_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pdl_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Asynchronous levels and their synchronous copies
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/pdl_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module pdl_divider (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Divider bundle
  pdl_div_if.div dv
);
  logic [pdl_pkg::RATIO_W-1:0] count;
  logic [pdl_pkg::RATIO_W-1:0] next_count;

  assign next_count = count + pdl_pkg::RATIO_ONE;

  // Toggle every ratio events: counting both input edges gives a square wave
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      dv.level <= 1'b0;
      dv.tick <= 1'b0;
      dv.rise <= 1'b0;
    end else if (dv.clear) begin
      count <= '0;
      dv.level <= 1'b0;
      dv.tick <= 1'b0;
      dv.rise <= 1'b0;
    end else begin
      dv.tick <= 1'b0;
      dv.rise <= 1'b0;
      if (dv.event_in) begin
        if (next_count >= dv.ratio) begin
          count <= '0;
          dv.level <= ~dv.level;
          dv.tick <= 1'b1;
          dv.rise <= ~dv.level;
        end else begin
          count <= next_count;
        end
      end
    end
  end

  chk_rise_level: assert property (@(posedge clock) disable iff (!rst_n)
    dv.rise |-> dv.level && dv.tick) else $error("rise pulse without high level");
endmodule
`default_nettype wire

/* File: rtl/pdl_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pdl_top (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Pins
  input wire logic logic_reset_n,
  input wire logic ref_clk_in,
  input wire logic vco_clk_in,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Clock outputs and loop control
  output logic [pdl_pkg::NUM_VDIV-1:0] out_clk,
  output logic pfd_up,
  output logic pfd_dn,
  output logic lock_n,
  output logic irq
);
  localparam int WIN = pdl_pkg::PHASE_WIN_CYC;
  localparam int LRST_CYC = pdl_pkg::LRST_MIN_CYC;

  function automatic logic [pdl_pkg::QUAL_W-1:0] clamp(input logic [31:0] val,
      input logic [pdl_pkg::QUAL_W-1:0] lo, input logic [pdl_pkg::QUAL_W-1:0] hi);
    logic [pdl_pkg::QUAL_W-1:0] res;
    res = lo;
    if (val > {23'h000000, hi}) res = hi;
    else if (val > {23'h000000, lo}) res = val[pdl_pkg::QUAL_W-1:0];
    return res;
  endfunction

  logic [1:0] rst_pipe;
  logic rst_n;
  logic [2:0] pin_sync;
  logic ref_s, vco_s, lrst_pin_n;
  logic ref_d, vco_d;
  logic ref_edge, vco_edge;
  logic [1:0] lrst_cnt;
  logic lrst;
  logic [6:0] ctrl;
  logic freq_mode, m_byp, n_byp, pll_byp;
  logic [2:0] fb_sel;
  logic [pdl_pkg::RATIO_W-1:0] m_ratio, n_ratio;
  logic [pdl_pkg::RATIO_W-1:0] v_ratio [pdl_pkg::NUM_VDIV];
  logic [pdl_pkg::QUAL_W-1:0] qual;
  logic [pdl_pkg::NUM_VDIV-1:0] v_tick, v_rise;
  logic m_edge, m_rise, fb_edge, fb_rise, pfd_ref, pfd_fbk;
  logic [1:0] irq_stat, irq_mask;
  logic wr_ctrl, wr_irq;

  // Reset release through two flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) rst_pipe <= 2'h0;
    else rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  pdl_sync #(.WIDTH(3)) u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({logic_reset_n, vco_clk_in, ref_clk_in}),
    .sync_out(pin_sync)
  );
  assign ref_s = pin_sync[0];
  assign vco_s = pin_sync[1];
  assign lrst_pin_n = pin_sync[2];

  // Only transitions matter, so any duty cycle works
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_d <= 1'b0;
      vco_d <= 1'b0;
    end else begin
      ref_d <= ref_s;
      vco_d <= vco_s;
    end
  end
  assign ref_edge = ref_s ^ ref_d;
  assign vco_edge = vco_s ^ vco_d;

  // Logic reset stretched to the minimum width; configuration survives it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) lrst_cnt <= 2'h0;
    else if (!lrst_pin_n) lrst_cnt <= 2'(LRST_CYC);
    else if (lrst_cnt != 2'h0) lrst_cnt <= lrst_cnt - 2'h1;
  end
  assign lrst = !lrst_pin_n || (lrst_cnt != 2'h0);

  // Register writes
  assign wr_ctrl = wr && (addr == pdl_pkg::ADDR_CTRL);
  assign wr_irq = wr && (addr == pdl_pkg::ADDR_IRQ_STAT);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) ctrl <= pdl_pkg::CTRL_RESET;
    else if (wr_ctrl) begin
      ctrl[3:0] <= wdata[3:0];
      ctrl[6:4] <= (wdata[6:4] > pdl_pkg::FBSEL_MAX) ? pdl_pkg::FBSEL_MAX : wdata[6:4];
    end
  end
  assign freq_mode = ctrl[pdl_pkg::CTRL_FREQ_BIT];
  assign m_byp = ctrl[pdl_pkg::CTRL_MBYP_BIT];
  assign n_byp = ctrl[pdl_pkg::CTRL_NBYP_BIT];
  assign pll_byp = ctrl[pdl_pkg::CTRL_PBYP_BIT];
  assign fb_sel = ctrl[pdl_pkg::CTRL_FBSEL_LSB +: 3];

  // Out-of-range ratios are clamped rather than refused
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      m_ratio <= pdl_pkg::PRE_RESET;
      n_ratio <= pdl_pkg::PRE_RESET;
    end else if (wr && addr == pdl_pkg::ADDR_M_RATIO) begin
      m_ratio <= 7'(clamp(wdata, pdl_pkg::PRE_MIN, pdl_pkg::PRE_MAX));
    end else if (wr && addr == pdl_pkg::ADDR_N_RATIO) begin
      n_ratio <= 7'(clamp(wdata, pdl_pkg::PRE_MIN, pdl_pkg::PRE_MAX));
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) qual <= pdl_pkg::QUAL_RESET;
    else if (wr && addr == pdl_pkg::ADDR_QUAL) begin
      qual <= clamp(wdata, pdl_pkg::QUAL_MIN, pdl_pkg::QUAL_MAX);
    end
  end

  // Output dividers and their feedback selection
  pdl_div_if m_if ();
  pdl_div_if n_if ();

  genvar k;
  for (k = 0; k < pdl_pkg::NUM_VDIV; k++) begin : g_vdiv
    pdl_div_if v_if ();
    logic [7:0] v_addr;
    logic [pdl_pkg::QUAL_W-1:0] v_clamp;
    assign v_addr = pdl_pkg::ADDR_V_BASE + 8'(4 * k);
    assign v_clamp = clamp(wdata, pdl_pkg::VDIV_MIN, pdl_pkg::VDIV_MAX);
    // Odd values rounded down so each divider stays even
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) v_ratio[k] <= pdl_pkg::VDIV_RESET;
      else if (wr && addr == v_addr) begin
        v_ratio[k] <= {v_clamp[6:1], 1'b0};
      end
    end
    assign v_if.clear = lrst;
    // Bypass halves the ratio and counts both prescaler edges instead of the VCO
    assign v_if.event_in = pll_byp ? m_edge : vco_edge;
    assign v_if.ratio = pll_byp ? {1'b0, v_ratio[k][6:1]} : v_ratio[k];
    assign v_tick[k] = v_if.tick;
    assign v_rise[k] = v_if.rise;
    assign out_clk[k] = v_if.level;
    pdl_divider u_vdiv (
      .clock(clock),
      .rst_n(rst_n),
      .dv(v_if)
    );
  end

  // Input prescaler, or the raw reference when bypassed
  assign m_if.clear = lrst || m_byp;
  assign m_if.event_in = ref_edge;
  assign m_if.ratio = m_ratio;
  pdl_divider u_mdiv (
    .clock(clock),
    .rst_n(rst_n),
    .dv(m_if)
  );
  assign m_edge = m_byp ? ref_edge : m_if.tick;
  assign m_rise = m_byp ? (ref_s && !ref_d) : m_if.rise;

  // Feedback prescaler on the selected divider
  assign fb_edge = v_tick[fb_sel];
  assign fb_rise = v_rise[fb_sel];
  assign n_if.clear = lrst || n_byp;
  assign n_if.event_in = fb_edge;
  assign n_if.ratio = n_ratio;
  pdl_divider u_ndiv (
    .clock(clock),
    .rst_n(rst_n),
    .dv(n_if)
  );
  assign pfd_ref = m_rise;
  assign pfd_fbk = n_byp ? fb_rise : n_if.rise;

  // Charge pump pulses: both set means both clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pfd_up <= 1'b0;
      pfd_dn <= 1'b0;
    end else if (lrst || pll_byp) begin
      pfd_up <= 1'b0;
      pfd_dn <= 1'b0;
    end else if ((pfd_up || pfd_ref) && (pfd_dn || pfd_fbk)) begin
      pfd_up <= 1'b0;
      pfd_dn <= 1'b0;
    end else begin
      pfd_up <= pfd_up || pfd_ref;
      pfd_dn <= pfd_dn || pfd_fbk;
    end
  end

  // Lock detector
  logic [pdl_pkg::CNT_W-1:0] since_ref, since_fbk;
  logic [1:0] fbk_cnt;
  logic pend, locked, locked_d;
  logic [pdl_pkg::QUAL_W-1:0] qcnt;
  logic good, bad, det_en, timeout;
  logic ph_good, ph_bad, fr_good, fr_bad;

  assign det_en = !pll_byp && !lrst;
  assign timeout = since_ref >= 10'(pdl_pkg::REF_TIMEOUT_CYC);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      since_ref <= '1;
      since_fbk <= '1;
      fbk_cnt <= 2'h0;
    end else if (!det_en) begin
      since_ref <= '1;
      since_fbk <= '1;
      fbk_cnt <= 2'h0;
    end else begin
      if (pfd_ref) since_ref <= '0;
      else if (since_ref != '1) since_ref <= since_ref + 10'h001;
      if (pfd_fbk) since_fbk <= '0;
      else if (since_fbk != '1) since_fbk <= since_fbk + 10'h001;
      if (pfd_ref) fbk_cnt <= 2'h0;
      else if (pfd_fbk && fbk_cnt != 2'h3) fbk_cnt <= fbk_cnt + 2'h1;
    end
  end

  // Phase judgement: feedback edge within the window around the reference edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) pend <= 1'b0;
    else if (!det_en) pend <= 1'b0;
    else if (pfd_ref) pend <= !(pfd_fbk || since_fbk <= 10'(WIN));
    else if (pend && (pfd_fbk || since_ref >= 10'(WIN))) pend <= 1'b0;
  end
  assign ph_good = (pfd_ref && (pfd_fbk || since_fbk <= 10'(WIN))) ||
                   (pend && !pfd_ref && pfd_fbk);
  assign ph_bad = pend && !pfd_ref && !pfd_fbk && since_ref >= 10'(WIN);
  // Frequency judgement: exactly one feedback edge per reference period
  assign fr_good = pfd_ref && (fbk_cnt + 2'(pfd_fbk) == 2'h1);
  assign fr_bad = pfd_ref && !fr_good;
  assign good = freq_mode ? fr_good : ph_good;
  assign bad = (freq_mode ? fr_bad : ph_bad) || timeout;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      locked <= 1'b0;
      qcnt <= '0;
    end else if (!det_en || bad) begin
      locked <= 1'b0;
      qcnt <= '0;
    end else if (good) begin
      if (!freq_mode) locked <= 1'b1;
      else if (qcnt + 9'h001 >= qual) begin
        locked <= 1'b1;
        qcnt <= qual;
      end else qcnt <= qcnt + 9'h001;
    end
  end
  assign lock_n = !locked;

  // Interrupts: set beats a same-cycle clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) locked_d <= 1'b0;
    else locked_d <= locked;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) irq_stat <= pdl_pkg::IRQ_RESET;
    else irq_stat <= (irq_stat & ~(wr_irq ? wdata[1:0] : 2'h0)) |
                     {locked_d && !locked, locked && !locked_d};
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) irq_mask <= pdl_pkg::IRQ_RESET;
    else if (wr && addr == pdl_pkg::ADDR_IRQ_MASK) irq_mask <= wdata[1:0];
  end
  assign irq = |(irq_stat & irq_mask);

  // Read data for one cycle only; unmapped reads give zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rdata <= 32'h00000000;
    else if (!rd) rdata <= 32'h00000000;
    else begin
      case (addr)
        pdl_pkg::ADDR_CTRL: rdata <= {25'h0000000, ctrl};
        pdl_pkg::ADDR_M_RATIO: rdata <= {25'h0000000, m_ratio};
        pdl_pkg::ADDR_N_RATIO: rdata <= {25'h0000000, n_ratio};
        pdl_pkg::ADDR_QUAL: rdata <= {23'h000000, qual};
        8'h10: rdata <= {25'h0000000, v_ratio[0]};
        8'h14: rdata <= {25'h0000000, v_ratio[1]};
        8'h18: rdata <= {25'h0000000, v_ratio[2]};
        8'h1C: rdata <= {25'h0000000, v_ratio[3]};
        8'h20: rdata <= {25'h0000000, v_ratio[4]};
        pdl_pkg::ADDR_STATUS: rdata <= {7'h00, qcnt, 13'h0000, pfd_dn, pfd_up, locked};
        pdl_pkg::ADDR_IRQ_STAT: rdata <= {30'h00000000, irq_stat};
        pdl_pkg::ADDR_IRQ_MASK: rdata <= {30'h00000000, irq_mask};
        default: rdata <= 32'h00000000;
      endcase
    end
  end

  sequence s_good_unlocked;
    det_en && !bad && good && !locked;
  endsequence
  chk_phase_first_lock: assert property (@(posedge clock) disable iff (!rst_n)
    s_good_unlocked ##0 !freq_mode |=> !lock_n) else $error("phase mode lock late");
  chk_freq_qual_count: assert property (@(posedge clock) disable iff (!rst_n)
    freq_mode && $rose(locked) |-> qcnt == qual && $past(qcnt) + 9'h001 >= qual)
    else $error("frequency lock before count reached");
  chk_freq_no_early: assert property (@(posedge clock) disable iff (!rst_n)
    s_good_unlocked ##0 freq_mode && qcnt + 9'h001 < qual |=> lock_n)
    else $error("frequency lock too early");
  chk_loss_at_once: assert property (@(posedge clock) disable iff (!rst_n)
    bad |=> lock_n && qcnt == '0) else $error("lock kept after loss");
  chk_bypass_no_lock: assert property (@(posedge clock) disable iff (!rst_n)
    pll_byp |=> lock_n) else $error("lock shown in bypass");
  chk_lrst_clears: assert property (@(posedge clock) disable iff (!rst_n)
    !lrst_pin_n |=> lock_n && out_clk == '0 && lrst) else $error("logic reset ineffective");
  chk_pfd_exclusive: assert property (@(posedge clock) disable iff (!rst_n)
    !(pfd_up && pfd_dn)) else $error("both pump pulses high");
  chk_irq_gain_set: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(locked) |=> irq_stat[pdl_pkg::IRQ_GAIN_BIT]) else $error("lock gain not flagged");
  chk_read_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
    !$past(rd) |-> rdata == 32'h00000000) else $error("read data outside slot");
  chk_vdiv_even: assert property (@(posedge clock) disable iff (!rst_n)
    !v_ratio[0][0] && v_ratio[0] >= 7'h02 && v_ratio[0] <= 7'h50) else $error("odd divider");
endmodule
`default_nettype wire

/* File: sim/pdl_clk_src.sv */
`timescale 1ns/1ps
`default_nettype none
module pdl_clk_src (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Controls
  input wire logic en,
  input wire logic vco_hold,
  input wire logic [7:0] ref_hi,
  input wire logic [7:0] ref_lo,
  input wire logic [7:0] vco_half,
  input wire logic [7:0] ref_lag,
  // Pins
  output logic ref_clk,
  output logic vco_clk
);
  logic [7:0] rc;
  logic [7:0] vc;
  // Both pins rest low while disabled, so every run starts with the phase that ref_lag sets
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_clk <= 1'b0;
      vco_clk <= 1'b0;
      rc <= 8'h00;
      vc <= 8'h00;
    end else if (!en) begin
      ref_clk <= 1'b0;
      vco_clk <= 1'b0;
      rc <= ref_lag;
      vc <= 8'h00;
    end else begin
      // High and low times set apart, so the duty cycle can be lopsided
      if (rc == 8'h00) begin
        ref_clk <= ~ref_clk;
        rc <= (ref_clk ? ref_lo : ref_hi) - 8'h01;
      end else begin
        rc <= rc - 8'h01;
      end
      // A stopped oscillator keeps its level rather than floating
      if (!vco_hold) begin
        if (vc == 8'h00) begin
          vco_clk <= ~vco_clk;
          vc <= vco_half - 8'h01;
        end else begin
          vc <= vc - 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock, reset_n, logic_reset_n, wr, rd;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [pdl_pkg::NUM_VDIV-1:0] out_clk;
  logic pfd_up, pfd_dn, lock_n, irq, ref_clk, vco_clk, en, vco_hold;
  logic [7:0] ref_hi, ref_lo, vco_half, ref_lag;
  int error_cnt, checks_done, cyc;

  pdl_top u_pdl_top (.clock(clock), .reset_n(reset_n), .logic_reset_n(logic_reset_n),
    .ref_clk_in(ref_clk), .vco_clk_in(vco_clk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .out_clk(out_clk), .pfd_up(pfd_up), .pfd_dn(pfd_dn),
    .lock_n(lock_n), .irq(irq));
  pdl_clk_src u_pdl_clk_src (.clock(clock), .rst_n(reset_n), .en(en), .vco_hold(vco_hold),
    .ref_hi(ref_hi), .ref_lo(ref_lo), .vco_half(vco_half), .ref_lag(ref_lag),
    .ref_clk(ref_clk), .vco_clk(vco_clk));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic summarize;
    $display("Checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Whole run needs well under this many cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    check(n, rdata, e);
  endtask

  task automatic wrchk(input string n, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e);
    wr_reg(a, d);
    rdchk(n, a, e);
  endtask

  task automatic wait_lock(input logic lv, input int max);
    int n;
    n = 0;
    while (lock_n !== lv && n < max) begin
      @(posedge clock);
      n++;
    end
  endtask

  // Cycles between two toggles of one output; the first toggle absorbs any transient
  task automatic meas(input string nm, input int k, input logic [31:0] e);
    int i;
    logic p;
    logic [31:0] n;
    n = 32'h0;
    p = out_clk[k];
    for (i = 0; i < 1000 && out_clk[k] === p; i++) @(posedge clock);
    p = out_clk[k];
    for (i = 0; i < 1000 && out_clk[k] === p; i++) begin
      @(posedge clock);
      n++;
    end
    check(nm, n, e);
  endtask

  task automatic restart(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] vh,
                         input logic [7:0] lag);
    @(posedge clock);
    en <= 1'b0;
    vco_hold <= 1'b0;
    logic_reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    logic_reset_n <= 1'b1;
    ref_hi <= hi;
    ref_lo <= lo;
    vco_half <= vh;
    ref_lag <= lag;
    repeat (4) @(posedge clock);
    en <= 1'b1;
  endtask

  task automatic t_regs;
    int k;
    rdchk("ctrl rst", 8'h00, 32'h0);
    rdchk("m rst", 8'h04, 32'h1);
    rdchk("n rst", 8'h08, 32'h1);
    rdchk("qual rst", 8'h0C, 32'h10);
    for (k = 0; k < 5; k++) rdchk("v rst", 8'h10 + 8'(4 * k), 32'h2);
    rdchk("status rst", 8'h24, 32'h0);
    rdchk("irq stat rst", 8'h28, 32'h0);
    rdchk("irq mask rst", 8'h2C, 32'h0);
    wrchk("m max", 8'h04, 32'h29, 32'h28);
    wrchk("m min", 8'h04, 32'h0, 32'h1);
    wrchk("n max", 8'h08, 32'h29, 32'h28);
    wrchk("v odd", 8'h10, 32'h7, 32'h6);
    wrchk("v max", 8'h14, 32'h51, 32'h50);
    wrchk("qual max", 8'h0C, 32'h12C, 32'h100);
    wrchk("qual min", 8'h0C, 32'hF, 32'h10);
    wrchk("fb select", 8'h00, 32'h7F, 32'h4F);
    wrchk("unmapped", 8'h30, 32'h5, 32'h0);
    wr_reg(8'h04, 32'h1);
    wr_reg(8'h08, 32'h1);
  endtask

  // Outputs run at the oscillator rate over their own ratio, set apart
  task automatic t_div;
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h10, 32'h2);
    wr_reg(8'h14, 32'h6);
    wr_reg(8'h20, 32'h50);
    restart(8'h03, 8'h03, 8'h03, 8'h00);
    meas("v1 ratio 2", 0, 32'd6);
    meas("v2 ratio 6", 1, 32'd18);
    meas("v4 ratio 2", 3, 32'd6);
    meas("v5 ratio 80", 4, 32'd240);
  endtask

  task automatic t_bypass;
    wr_reg(8'h00, 32'h8);
    wr_reg(8'h04, 32'h3);
    wr_reg(8'h10, 32'h4);
    restart(8'h03, 8'h03, 8'h03, 8'h03);
    meas("bypass m3 v4", 0, 32'd18);
    check("bypass lock", {31'h0, lock_n}, 32'h1);
    wr_reg(8'h00, 32'hA);
    meas("m bypass", 0, 32'd6);
    check("bypass lock", {31'h0, lock_n}, 32'h1);
  endtask

  task automatic t_freq(input int q);
    int r, n;
    logic p;
    wr_reg(8'h28, 32'h3);
    wr_reg(8'h00, 32'h1);
    wr_reg(8'h04, 32'h1);
    wr_reg(8'h08, 32'h1);
    wr_reg(8'h10, 32'h2);
    wr_reg(8'h0C, 32'(q));
    restart(8'h04, 8'h08, 8'h03, 8'h00);
    r = 0;
    n = 0;
    p = 1'b0;
    while (lock_n !== 1'b0 && n < 5000) begin
      @(posedge clock);
      n++;
      if (ref_clk && !p) r++;
      p = ref_clk;
    end
    check("freq lock", {31'h0, lock_n}, 32'h0);
    check("freq count", {31'h0, r >= q && r <= q + 3}, 32'h1);
    vco_hold <= 1'b1;
    wait_lock(1'b1, 40);
    check("freq loss", {31'h0, lock_n}, 32'h1);
    // Reference edges keep coming with no feedback, so only the up pulse stands
    check("pump up only", {30'h0, pfd_dn, pfd_up}, 32'h1);
    rdchk("qual cleared", 8'h24, 32'h2);
  endtask

  task automatic t_irq;
    wr_reg(8'h2C, 32'h0);
    rdchk("irq events", 8'h28, 32'h3);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr_reg(8'h2C, 32'h2);
    @(posedge clock);
    check("irq raised", {31'h0, irq}, 32'h1);
    wr_reg(8'h28, 32'h2);
    @(posedge clock);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rdchk("irq w1c", 8'h28, 32'h1);
    wr_reg(8'h28, 32'h1);
    rdchk("irq w1c", 8'h28, 32'h0);
  endtask

  task automatic t_phase;
    wr_reg(8'h00, 32'h20);
    wr_reg(8'h18, 32'h2);
    restart(8'h06, 8'h06, 8'h03, 8'h03);
    wait_lock(1'b0, 30);
    check("phase lock", {31'h0, lock_n}, 32'h0);
    meas("fb drives out", 2, 32'd6);
    @(posedge clock);
    logic_reset_n <= 1'b0;
    repeat (4) @(posedge clock);
    check("logic reset", {31'h0, lock_n}, 32'h1);
    rdchk("config kept", 8'h00, 32'h20);
    // Relock with the feedback prescaler bypassed; then no feedback must drop the lock
    wr_reg(8'h00, 32'h24);
    restart(8'h06, 8'h06, 8'h03, 8'h03);
    wait_lock(1'b0, 30);
    check("relock", {31'h0, lock_n}, 32'h0);
    vco_hold <= 1'b1;
    wait_lock(1'b1, 25);
    check("phase loss", {31'h0, lock_n}, 32'h1);
  endtask

  initial begin
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    reset_n = 1'b0;
    logic_reset_n = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    en = 1'b0;
    vco_hold = 1'b0;
    ref_hi = 8'h03;
    ref_lo = 8'h03;
    vco_half = 8'h03;
    ref_lag = 8'h00;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_regs();
    t_div();
    t_bypass();
    t_freq(16);
    t_irq();
    t_freq(256);
    t_phase();
    summarize();
  end
endmodule
`default_nettype wire
